// >>> src/mcu_exec.sv
// Execute unit for logic, rotate, bit, skip, branch and context instructions.
//
// Behaviour
// - RAM write-back adds a cycle, except for clear; system registers add none.
// - A taken skip adds a cycle.
// - AND with memory or immediate; zero updated, carries kept.
// - OR with memory or immediate; carries kept.
// - XOR with memory or immediate; zero updated, carries kept.
// - Nibble swap of memory into accumulator, one cycle, flags kept.
// - Nibble swap of memory in place, flags kept.
// - Bit clear and set touch one bit, flags kept.
// - Compare memory sets zero and carry, skips when equal.
// - Increment to accumulator, skip on zero, flags kept.
// - Increment in place, skip on zero, flags kept.
// - Decrement to accumulator, skip on zero, flags kept.
// - Decrement in place, skip on zero.
// - Bit test skips when the bit equals the opcode's value.
// - Bank zero bit forms address bank zero.
// - Jump takes two cycles; page bits fill counter bits 15-14.
// - Call pushes the counter plus one, then jumps; two cycles.
// - Returns pop the counter in two cycles; interrupt return sets enable.
// - Context save copies accumulator and flags, status bits excluded.
// - Context restore reloads them, status bits kept.
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module mcu_exec
   import exec_pkg::*;
#(
   parameter int STACK_DEPTH = 8
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic reset,
   // Instruction stream.
   input wire logic instr_valid,
   input wire instr_s instr,
   output logic instr_ready,
   // Data memory write-back.
   output logic wb_valid,
   output wback_s wb,
   // Core state.
   output logic [7:0] accumulator_reg,
   output logic [7:0] program_flag_reg,
   output logic [PC_W-1:0] pc,
   output logic skip_pulse,
   output logic gie,
   // Status bits kept by the reset and watchdog logic.
   input wire logic timeout_status_bit,
   input wire logic powerdown_status_bit,
   // AXI4-Lite slave.
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [AXI_DW-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [AXI_DW-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   localparam int SP_W = $clog2(STACK_DEPTH);

   exec_state_e state_reg, state_next;
   logic [1:0] stall_reg, stall_next;
   logic [7:0] acc_next, flag_next, result;
   logic [7:0] save_acc_reg, save_flag_reg;
   logic [PC_W-1:0] pc_next, push_value;
   logic [PC_W-1:0] stack_mem [STACK_DEPTH];
   logic [SP_W-1:0] sp_reg;
   logic [1:0] page_reg;
   logic [31:0] count_reg;
   logic mem_write, do_skip, do_branch, do_push, do_pop, do_interrupt_return, do_save;

   // Operand helpers.
   wire logic take = instr_valid && instr_ready;
   wire logic [7:0] opnd = instr.operand;
   wire logic [7:0] and_v = accumulator_reg & opnd;
   wire logic [7:0] or_v = accumulator_reg | opnd;
   wire logic [7:0] xor_v = accumulator_reg ^ opnd;
   wire logic [7:0] and_i = accumulator_reg & instr.imm;
   wire logic [7:0] or_i = accumulator_reg | instr.imm;
   wire logic [7:0] xor_i = accumulator_reg ^ instr.imm;
   wire logic [7:0] swap_v = {opnd[3:0], opnd[7:4]};
   wire logic carry_in = program_flag_reg[FLAG_CARRY];
   wire logic [7:0] rrc_v = {carry_in, opnd[7:1]};
   wire logic [7:0] rlc_v = {opnd[6:0], carry_in};
   wire logic [7:0] bit_mask = BYTE_ONE << instr.bitsel;
   wire logic sel_bit = opnd[instr.bitsel];
   wire logic [7:0] inc_v = opnd + BYTE_ONE;
   wire logic [7:0] dec_v = opnd - BYTE_ONE;
   wire logic [8:0] cmp_i = {1'b0, accumulator_reg} - {1'b0, instr.imm};
   wire logic [8:0] cmp_m = {1'b0, accumulator_reg} - {1'b0, opnd};
   wire logic [PC_W-1:0] jump_pc = {page_reg, instr.target};
   wire logic [SP_W-1:0] sp_top = sp_reg - SP_W'(1);
   wire logic ram_cost = mem_write && !instr.sysreg && (instr.op != op_clear_mem);
   wire logic bank0_form = instr.op inside {op_bank_zero_bit_clear, op_bank_zero_bit_set,
      op_bank_zero_skip_if_low, op_bank_zero_skip_if_high};

   // Datapath and decode of the instruction offered this cycle.
   always_comb begin
      acc_next = accumulator_reg;
      flag_next = program_flag_reg;
      result = opnd;
      mem_write = 1'b0;
      do_skip = 1'b0;
      do_branch = 1'b0;
      do_push = 1'b0;
      do_pop = 1'b0;
      do_interrupt_return = 1'b0;
      do_save = 1'b0;
      unique case (instr.op)
         op_and_acc_mem: begin
            acc_next = and_v;
            flag_next[FLAG_ZERO] = (and_v == BYTE_ZERO);
         end
         op_and_mem_acc: begin
            result = and_v;
            mem_write = 1'b1;
            flag_next[FLAG_ZERO] = (and_v == BYTE_ZERO);
         end
         op_and_acc_imm: begin
            acc_next = and_i;
            flag_next[FLAG_ZERO] = (and_i == BYTE_ZERO);
         end
         op_or_acc_mem: begin
            acc_next = or_v;
            flag_next[FLAG_ZERO] = (or_v == BYTE_ZERO);
         end
         op_or_mem_acc: begin
            result = or_v;
            mem_write = 1'b1;
            flag_next[FLAG_ZERO] = (or_v == BYTE_ZERO);
         end
         op_or_acc_imm: begin
            acc_next = or_i;
            flag_next[FLAG_ZERO] = (or_i == BYTE_ZERO);
         end
         op_xor_acc_mem: begin
            acc_next = xor_v;
            flag_next[FLAG_ZERO] = (xor_v == BYTE_ZERO);
         end
         op_xor_mem_acc: begin
            result = xor_v;
            mem_write = 1'b1;
            flag_next[FLAG_ZERO] = (xor_v == BYTE_ZERO);
         end
         op_xor_acc_imm: begin
            acc_next = xor_i;
            flag_next[FLAG_ZERO] = (xor_i == BYTE_ZERO);
         end
         op_nibble_exchange: acc_next = swap_v;
         op_nibble_exchange_in_place: begin
            result = swap_v;
            mem_write = 1'b1;
         end
         op_rotate_right_carry: begin
            acc_next = rrc_v;
            flag_next[FLAG_CARRY] = opnd[0];
         end
         op_rotate_right_in_place: begin
            result = rrc_v;
            mem_write = 1'b1;
            flag_next[FLAG_CARRY] = opnd[0];
         end
         op_rotate_left_carry: begin
            acc_next = rlc_v;
            flag_next[FLAG_CARRY] = opnd[7];
         end
         op_rotate_left_in_place: begin
            result = rlc_v;
            mem_write = 1'b1;
            flag_next[FLAG_CARRY] = opnd[7];
         end
         op_clear_mem: begin
            // A clear always finishes in one cycle, whatever the operand is.
            result = BYTE_ZERO;
            mem_write = 1'b1;
         end
         op_bit_clear_op, op_bank_zero_bit_clear: begin
            result = opnd & ~bit_mask;
            mem_write = 1'b1;
         end
         op_bit_set_op, op_bank_zero_bit_set: begin
            result = opnd | bit_mask;
            mem_write = 1'b1;
         end
         op_compare_skip_imm: begin
            flag_next[FLAG_ZERO] = (cmp_i[7:0] == BYTE_ZERO);
            flag_next[FLAG_CARRY] = !cmp_i[8];
            do_skip = (cmp_i[7:0] == BYTE_ZERO);
         end
         op_compare_skip_mem: begin
            flag_next[FLAG_ZERO] = (cmp_m[7:0] == BYTE_ZERO);
            flag_next[FLAG_CARRY] = !cmp_m[8];
            do_skip = (cmp_m[7:0] == BYTE_ZERO);
         end
         op_increment_to_acc_skip: begin
            acc_next = inc_v;
            do_skip = (inc_v == BYTE_ZERO);
         end
         op_increment_in_place_skip: begin
            result = inc_v;
            mem_write = 1'b1;
            do_skip = (inc_v == BYTE_ZERO);
         end
         op_decrement_to_acc_skip: begin
            acc_next = dec_v;
            do_skip = (dec_v == BYTE_ZERO);
         end
         op_decrement_in_place_skip: begin
            result = dec_v;
            mem_write = 1'b1;
            do_skip = (dec_v == BYTE_ZERO);
         end
         op_skip_if_bit_low, op_bank_zero_skip_if_low: do_skip = !sel_bit;
         op_skip_if_bit_high, op_bank_zero_skip_if_high: do_skip = sel_bit;
         op_jump: do_branch = 1'b1;
         op_call: begin
            do_branch = 1'b1;
            do_push = 1'b1;
         end
         op_return: do_pop = 1'b1;
         op_interrupt_return: begin
            do_pop = 1'b1;
            do_interrupt_return = 1'b1;
         end
         op_context_save: do_save = 1'b1;
         op_context_restore: begin
            acc_next = save_acc_reg;
            flag_next = (save_flag_reg & CONTEXT_MASK) |
               (program_flag_reg & ~CONTEXT_MASK);
         end
         op_no_operation: acc_next = accumulator_reg;
         default: acc_next = accumulator_reg;
      endcase
   end

   // Counter selection and stall cycles beyond the first.
   assign push_value = pc + PC_STEP;
   assign pc_next = do_branch ? jump_pc :
      do_pop ? stack_mem[sp_top] :
      do_skip ? pc + PC_SKIP : pc + PC_STEP;
   assign stall_next = take ? ({1'b0, ram_cost} + {1'b0, do_skip} +
      {1'b0, do_branch | do_pop}) :
      (stall_reg != 2'h0) ? stall_reg - 2'h1 : 2'h0;
   assign state_next = (stall_next != 2'h0) ? st_stall : st_ready;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_reg <= st_ready;
         stall_reg <= 2'h0;
         instr_ready <= 1'b1;
      end else begin
         state_reg <= state_next;
         stall_reg <= stall_next;
         instr_ready <= (state_next == st_ready);
      end
   end

   // Architectural state; the status bits always follow their owners.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         accumulator_reg <= BYTE_ZERO;
         program_flag_reg <= FLAG_RESET;
         pc <= PC_RESET;
         sp_reg <= '0;
         save_acc_reg <= BYTE_ZERO;
         save_flag_reg <= FLAG_RESET;
         wb_valid <= 1'b0;
         wb <= '0;
         skip_pulse <= 1'b0;
         count_reg <= '0;
      end else begin
         wb_valid <= take && mem_write;
         skip_pulse <= take && do_skip;
         if (take) begin
            accumulator_reg <= acc_next;
            pc <= pc_next;
            count_reg <= count_reg + 32'h1;
            wb <= '{bank0: bank0_form, addr: instr.addr, data: result};
            if (do_push) begin
               sp_reg <= sp_reg + SP_W'(1);
            end else if (do_pop) begin
               sp_reg <= sp_top;
            end
            if (do_save) begin
               save_acc_reg <= accumulator_reg;
               save_flag_reg <= program_flag_reg & CONTEXT_MASK;
            end
         end
         program_flag_reg <= take ? flag_next : program_flag_reg;
         program_flag_reg[FLAG_TIMEOUT] <= timeout_status_bit;
         program_flag_reg[FLAG_POWERDOWN] <= powerdown_status_bit;
      end
   end

   // The return stack is plain storage and needs no reset.
   always_ff @(posedge mclk) begin
      if (take && do_push) begin
         stack_mem[sp_reg] <= push_value;
      end
   end

   // Register bus: write channel, address and data taken together.
   wire logic wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
   wire logic wr_ctrl = s_axi_awready && (s_axi_awaddr == CTRL_OFFSET) && s_axi_wstrb[0];
   wire logic wr_hit = (s_axi_awaddr == CTRL_OFFSET) || (s_axi_awaddr == STATE_OFFSET) ||
      (s_axi_awaddr == PC_OFFSET) || (s_axi_awaddr == COUNT_OFFSET);
   wire logic rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
   wire logic [AXI_DW-1:0] ctrl_word = {29'h0, gie, page_reg};
   wire logic [AXI_DW-1:0] state_word = {16'h0, program_flag_reg, accumulator_reg};
   wire logic [AXI_DW-1:0] pc_word = {{(AXI_DW-PC_W-SP_W){1'b0}}, sp_reg, pc};
   wire logic rd_hit = (s_axi_araddr == CTRL_OFFSET) || (s_axi_araddr == STATE_OFFSET) ||
      (s_axi_araddr == PC_OFFSET) || (s_axi_araddr == COUNT_OFFSET);
   wire logic [AXI_DW-1:0] rd_word = (s_axi_araddr == CTRL_OFFSET) ? ctrl_word :
      (s_axi_araddr == STATE_OFFSET) ? state_word :
      (s_axi_araddr == PC_OFFSET) ? pc_word :
      (s_axi_araddr == COUNT_OFFSET) ? count_reg : '0;
   // Interrupt return wins over a software clear in the same cycle.
   wire logic gie_next = (take && do_interrupt_return) ? 1'b1 :
      wr_ctrl ? s_axi_wdata[CTRL_GIE_BIT] : gie;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         page_reg <= PAGE_RESET;
         gie <= 1'b0;
      end else begin
         s_axi_awready <= wr_go;
         s_axi_wready <= wr_go;
         gie <= gie_next;
         if (wr_ctrl) begin
            page_reg <= s_axi_wdata[CTRL_PAGE_LSB +: 2];
         end
         if (s_axi_awready) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= rd_go;
         if (s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // mcu_exec

`default_nettype wire

// >>> src/exec_pkg.sv
// Package with opcodes, operand carriers, flag layout and register map of the execute unit.
package exec_pkg;

   localparam int DATA_W = 8;
   localparam int PC_W = 16;
   localparam int TARGET_W = 14;
   localparam int AXI_AW = 8;
   localparam int AXI_DW = 32;

   // Program flag layout.
   localparam int FLAG_ZERO = 0;
   localparam int FLAG_DIGIT = 1;
   localparam int FLAG_CARRY = 2;
   localparam int FLAG_POWERDOWN = 6;
   localparam int FLAG_TIMEOUT = 7;
   localparam logic [7:0] CONTEXT_MASK = 8'h3F;
   localparam logic [7:0] FLAG_RESET = 8'h00;

   // Register byte offsets.
   localparam logic [AXI_AW-1:0] CTRL_OFFSET = 8'h00;
   localparam logic [AXI_AW-1:0] STATE_OFFSET = 8'h04;
   localparam logic [AXI_AW-1:0] PC_OFFSET = 8'h08;
   localparam logic [AXI_AW-1:0] COUNT_OFFSET = 8'h0C;

   // Control register fields.
   localparam int CTRL_PAGE_LSB = 0;
   localparam int CTRL_GIE_BIT = 2;
   localparam logic [1:0] PAGE_RESET = 2'h0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
   localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
   localparam logic [PC_W-1:0] PC_SKIP = 16'h0002;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   typedef enum logic [5:0] {
      op_and_acc_mem = 6'h00, op_and_mem_acc = 6'h01, op_and_acc_imm = 6'h02,
      op_or_acc_mem = 6'h03, op_or_mem_acc = 6'h04, op_or_acc_imm = 6'h05,
      op_xor_acc_mem = 6'h06, op_xor_mem_acc = 6'h07, op_xor_acc_imm = 6'h08,
      op_nibble_exchange = 6'h09, op_nibble_exchange_in_place = 6'h0A,
      op_rotate_right_carry = 6'h0B, op_rotate_right_in_place = 6'h0C,
      op_rotate_left_carry = 6'h0D, op_rotate_left_in_place = 6'h0E,
      op_clear_mem = 6'h0F, op_bit_clear_op = 6'h10, op_bit_set_op = 6'h11,
      op_bank_zero_bit_clear = 6'h12, op_bank_zero_bit_set = 6'h13,
      op_compare_skip_imm = 6'h14, op_compare_skip_mem = 6'h15,
      op_increment_to_acc_skip = 6'h16, op_increment_in_place_skip = 6'h17,
      op_decrement_to_acc_skip = 6'h18, op_decrement_in_place_skip = 6'h19,
      op_skip_if_bit_low = 6'h1A, op_skip_if_bit_high = 6'h1B,
      op_bank_zero_skip_if_low = 6'h1C, op_bank_zero_skip_if_high = 6'h1D,
      op_jump = 6'h1E, op_call = 6'h1F, op_return = 6'h20,
      op_interrupt_return = 6'h21, op_context_save = 6'h22,
      op_context_restore = 6'h23, op_no_operation = 6'h24
   } op_e;

   typedef struct packed {
      op_e op;
      logic [7:0] addr;
      logic [2:0] bitsel;
      logic [7:0] imm;
      logic [7:0] operand;
      logic sysreg;
      logic [TARGET_W-1:0] target;
   } instr_s;

   typedef struct packed {
      logic bank0;
      logic [7:0] addr;
      logic [7:0] data;
   } wback_s;

   typedef enum logic [0:0] {
      st_ready = 1'b0,
      st_stall = 1'b1
   } exec_state_e;

endpackage

// >>> tb/mcu_exec_checker.sv
// Concurrent checks on the execute unit's instruction and state ports.
`timescale 1ns/100ps
`default_nettype none
module mcu_exec_checker
   import exec_pkg::*;
(
   // Clock, reset and instruction side.
   input wire logic mclk,
   input wire logic reset,
   input wire logic instr_valid,
   input wire instr_s instr,
   input wire logic instr_ready,
   // Results and status.
   input wire logic wb_valid,
   input wire wback_s wb,
   input wire logic [7:0] accumulator_reg,
   input wire logic [7:0] program_flag_reg,
   input wire logic [PC_W-1:0] pc,
   input wire logic skip_pulse,
   input wire logic timeout_status_bit,
   input wire logic powerdown_status_bit
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   wire take = instr_valid && instr_ready;
   wire plain_write = instr.op inside {op_and_mem_acc, op_or_mem_acc, op_xor_mem_acc,
      op_nibble_exchange_in_place, op_rotate_right_in_place, op_rotate_left_in_place,
      [op_bit_clear_op:op_bank_zero_bit_set]};
   AST_CLEAR: assert property (
      take && instr.op == op_clear_mem |=> wb_valid && wb.data == BYTE_ZERO && instr_ready)
      else $error("clear wrong or stalled");
   AST_NOP: assert property (
      take && instr.op == op_no_operation |=> instr_ready && !wb_valid && pc == $past(pc) + PC_STEP)
      else $error("no-operation stalled or changed state");
   AST_JUMP: assert property (
      take && instr.op == op_jump |=> pc[13:0] == $past(instr.target) && !instr_ready ##1 instr_ready)
      else $error("jump target or two-cycle timing wrong");
   AST_RAM_WRITE: assert property (
      take && plain_write && !instr.sysreg |=> wb_valid && !instr_ready ##1 instr_ready)
      else $error("RAM write-back timing wrong");
   AST_SYS_WRITE: assert property (
      take && plain_write && instr.sysreg |=> wb_valid && instr_ready)
      else $error("system register write-back stalled");
   AST_SKIP_TAKEN: assert property (
      take && instr.op == op_skip_if_bit_high && instr.operand[instr.bitsel]
      |=> skip_pulse && pc == $past(pc) + PC_SKIP && !instr_ready ##1 instr_ready)
      else $error("taken bit test wrong");
   AST_SKIP_HELD: assert property (
      take && instr.op == op_skip_if_bit_low && instr.operand[instr.bitsel]
      |=> !skip_pulse && instr_ready && pc == $past(pc) + PC_STEP)
      else $error("false bit test skipped or stalled");
   AST_SWAP: assert property (
      take && instr.op == op_nibble_exchange |=> instr_ready
      && accumulator_reg == {$past(instr.operand[3:0]), $past(instr.operand[7:4])}
      && program_flag_reg[5:0] == $past(program_flag_reg[5:0]))
      else $error("nibble swap wrong");
   AST_INC_WRAP: assert property (
      take && instr.op == op_increment_in_place_skip && !instr.sysreg && instr.operand == 8'hFF
      |=> wb_valid && wb.data == BYTE_ZERO && skip_pulse && !instr_ready ##1 !instr_ready
      ##1 instr_ready)
      else $error("wrapping increment wrong");
   AST_STATUS: assert property (
      !$past(reset) |-> program_flag_reg[7] == $past(timeout_status_bit)
      && program_flag_reg[6] == $past(powerdown_status_bit))
      else $error("status bits do not follow their inputs");
endmodule // mcu_exec_checker

bind mcu_exec mcu_exec_checker chk (.*);
`default_nettype wire

// >>> tb/data_store.sv
// Data memory and system register file model on the far side of the execute unit.
`timescale 1ns/100ps
`default_nettype none
module data_store
   import exec_pkg::*;
(
   // Clock and write-back.
   input wire logic mclk,
   input wire logic wb_valid,
   input wire wback_s wb
);
   // Bank selection lives outside the unit.
   logic [7:0] ram [256];
   initial begin
      for (int i = 0; i < 256; i++) begin
         ram[i] = 8'(i * 8'h3B + 8'h11);
      end
   end
   always @(posedge mclk) begin
      if (wb_valid === 1'h1) begin
         ram[wb.addr] <= wb.data;
      end
   end
endmodule // data_store
`default_nettype wire

// >>> tb/mcu_exec_tb.sv
// Self-checking bench for the execute unit against a behavioural model.
`timescale 1ns/100ps
`default_nettype none
module mcu_exec_tb;
   import exec_pkg::*;
   logic mclk = 1'h0, reset = 1'h1, instr_valid = 1'h0;
   logic timeout_status_bit = 1'h0, powerdown_status_bit = 1'h0;
   instr_s instr = '0;
   logic instr_ready, wb_valid, skip_pulse, gie;
   wback_s wb;
   logic [7:0] accumulator_reg, program_flag_reg;
   logic [PC_W-1:0] pc;
   logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [AXI_DW-1:0] s_axi_wdata = '0;
   logic [AXI_DW-1:0] s_axi_rdata;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [7:0] m_acc = 8'h00, m_fl = 8'h00, sv_acc = 8'h00, sv_fl = 8'h00;
   logic [PC_W-1:0] m_pc = 16'h0000;
   logic [PC_W-1:0] stk[$];
   logic [1:0] page = 2'h0;
   logic m_gie = 1'h0;
   logic [31:0] q;
   int n_mismatch = 0, samples_checked = 0, cyc = 0;

   mcu_exec dut (.*);
   data_store mem (.mclk, .wb_valid, .wb);

   always #50 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         final_report();
      end
   end

   task automatic final_report();
      $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // Offers both channels of a write, or a read, and releases each when it is taken.
   task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] s);
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      do begin
         @(posedge mclk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'h1);
      q = s_axi_rdata;
      rsp = w ? s_axi_bresp : s_axi_rresp;
      s_axi_bready <= 1'h0;
      s_axi_rready <= 1'h0;
   endtask
   task automatic issue(input op_e op, input logic [7:0] a, input logic [2:0] b,
         input logic [7:0] im, input logic [13:0] t);
      logic [7:0] m, o, r;
      logic wr, skp, brn;
      int n;
      m = mem.ram[a];
      o = (op inside {op_and_acc_imm, op_or_acc_imm, op_xor_acc_imm, op_compare_skip_imm}) ? im : m;
      r = m;
      skp = 1'h0;
      brn = op inside {[op_jump:op_interrupt_return]};
      wr = op inside {op_and_mem_acc, op_or_mem_acc, op_xor_mem_acc, op_nibble_exchange_in_place,
         op_rotate_right_in_place, op_rotate_left_in_place, [op_clear_mem:op_bank_zero_bit_set],
         op_increment_in_place_skip, op_decrement_in_place_skip};
      case (op)
         op_and_acc_mem, op_and_mem_acc, op_and_acc_imm: r = m_acc & o;
         op_or_acc_mem, op_or_mem_acc, op_or_acc_imm: r = m_acc | o;
         op_xor_acc_mem, op_xor_mem_acc, op_xor_acc_imm: r = m_acc ^ o;
         op_nibble_exchange, op_nibble_exchange_in_place: r = {m[3:0], m[7:4]};
         op_rotate_right_carry, op_rotate_right_in_place: r = {m_fl[FLAG_CARRY], m[7:1]};
         op_rotate_left_carry, op_rotate_left_in_place: r = {m[6:0], m_fl[FLAG_CARRY]};
         op_clear_mem: r = BYTE_ZERO;
         op_bit_clear_op, op_bank_zero_bit_clear: r[b] = 1'h0;
         op_bit_set_op, op_bank_zero_bit_set: r[b] = 1'h1;
         op_compare_skip_imm, op_compare_skip_mem: skp = m_acc == o;
         op_increment_to_acc_skip, op_increment_in_place_skip: skp = (r = m + 8'h01) == 8'h00;
         op_decrement_to_acc_skip, op_decrement_in_place_skip: skp = (r = m - 8'h01) == 8'h00;
         op_skip_if_bit_low, op_bank_zero_skip_if_low: skp = !m[b];
         op_skip_if_bit_high, op_bank_zero_skip_if_high: skp = m[b];
         default: ;
      endcase
      if (op <= op_xor_acc_imm) m_fl[FLAG_ZERO] = r == 8'h00;
      if (op inside {[op_rotate_right_carry:op_rotate_left_in_place]})
         m_fl[FLAG_CARRY] = op < op_rotate_left_carry ? m[0] : m[7];
      if (op inside {op_compare_skip_imm, op_compare_skip_mem}) begin
         m_fl[FLAG_ZERO] = skp;
         m_fl[FLAG_CARRY] = m_acc >= o;
      end
      if (op inside {op_and_acc_mem, op_and_acc_imm, op_or_acc_mem, op_or_acc_imm, op_xor_acc_mem,
         op_xor_acc_imm, op_nibble_exchange, op_rotate_right_carry, op_rotate_left_carry,
         op_increment_to_acc_skip, op_decrement_to_acc_skip}) m_acc = r;
      m_pc = m_pc + (skp ? PC_SKIP : PC_STEP);
      if (op == op_call) stk.push_back(m_pc);
      if (op inside {op_jump, op_call}) m_pc = {page, t};
      if (op inside {op_return, op_interrupt_return}) m_pc = stk.pop_back();
      if (op == op_interrupt_return) m_gie = 1'h1;
      if (op == op_context_save) begin
         sv_acc = m_acc;
         sv_fl = m_fl & CONTEXT_MASK;
      end
      if (op == op_context_restore) begin
         m_acc = sv_acc;
         m_fl[5:0] = sv_fl[5:0];
      end
      @(posedge mclk);
      instr_valid <= 1'h1;
      instr <= '{op, a, b, im, m, a[7], t};
      timeout_status_bit <= 1'($urandom);
      powerdown_status_bit <= 1'($urandom);
      @(posedge mclk);
      instr_valid <= 1'h0;
      @(negedge mclk);
      chk(accumulator_reg, m_acc);
      chk(program_flag_reg[5:0], m_fl[5:0]);
      chk(pc, m_pc);
      chk({skip_pulse, wb_valid, gie, wb.bank0 & wr}, {skp, wr, m_gie, wr &&
         op inside {op_bank_zero_bit_clear, op_bank_zero_bit_set}});
      if (wr) chk({wb.addr, wb.data}, {a, r});
      n = 0;
      while (instr_ready !== 1'h1 && n < 4) begin
         n++;
         @(negedge mclk);
      end
      chk(16'(n), 16'(wr && !a[7] && op != op_clear_mem) + 16'(skp) + 16'(brn));
   endtask

   initial begin
      int k;
      k = $urandom(56563);
      repeat (5) @(posedge mclk);
      reset <= 1'h0;
      axi(1'h0, CTRL_OFFSET, 32'h0, 4'h0);
      chk(q[15:0], PAGE_RESET);
      axi(1'h1, CTRL_OFFSET, 32'h7, 4'h0);
      axi(1'h1, CTRL_OFFSET, 32'h2, 4'hF);
      page = 2'h2;
      axi(1'h1, STATE_OFFSET, 32'hFF, 4'hF);
      chk(rsp, RESP_OKAY);
      axi(1'h0, CTRL_OFFSET, 32'h0, 4'h0);
      chk(q[15:0], 16'h0002);
      for (int w = 1; w >= 0; w--) begin
         axi(1'(w), 8'h40, 32'h5, 4'hF);
         chk(rsp, RESP_SLVERR);
      end
      chk(q[15:0], 16'h0000);
      issue(op_clear_mem, 8'h10, 3'h0, 8'h00, 14'h0000);
      issue(op_decrement_in_place_skip, 8'h10, 3'h0, 8'h00, 14'h0000);
      issue(op_increment_in_place_skip, 8'h10, 3'h0, 8'h00, 14'h0000);
      issue(op_jump, 8'h00, 3'h0, 8'h00, 14'h1234);
      issue(op_call, 8'h00, 3'h0, 8'h00, 14'h0456);
      issue(op_call, 8'h00, 3'h0, 8'h00, 14'h3FFF);
      issue(op_return, 8'h00, 3'h0, 8'h00, 14'h0000);
      issue(op_interrupt_return, 8'h00, 3'h0, 8'h00, 14'h0000);
      axi(1'h0, CTRL_OFFSET, 32'h0, 4'h0);
      chk(q[15:0], 16'h0006);
      for (int i = 0; i < 400; i++) begin
         k = $urandom_range(32);
         // Branches stay out of the random stream; bank zero bit operations and nibble exchanges are in it.
         issue(op_e'(k < 30 ? k : k + 4), 8'($urandom), 3'($urandom), 8'($urandom),
            14'($urandom));
      end
      axi(1'h0, STATE_OFFSET, 32'h0, 4'h0);
      chk(q[13:0], {m_fl[5:0], m_acc});
      axi(1'h0, PC_OFFSET, 32'h0, 4'h0);
      chk(q[15:0], m_pc);
      final_report();
   end
endmodule // mcu_exec_tb
`default_nettype wire
